// ### acs_calibration_control.sv
// acs_calibration_control: calibration sequencing on the sample clock and output demultiplexing
// on the conversion word clock, with level crossings between the two.
// assumes reset_in is released with ref_clk_in running; conv_clk_in delivers one core sample per rising edge,
// alternating falling-edge and rising-edge conversions, starting with a falling-edge one after reset.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////////////////////////
// input synchroniser: AGREE=1 takes a change once the second and third stages agree,
// AGREE=0 is a plain three-stage level crossing
module acs_sync #(
    parameter int W     = 1,
    parameter bit AGREE = 1'b1
) (
    input  wire logic         clk_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk_in) begin
        s1_reg <= d_in;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    // no reset on purpose: a constant here would fake a pin level at start-up
    always_ff @(posedge clk_in) begin
        if (!AGREE) begin
            q_out <= s2_reg;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q_out[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////////////////////////
module acs_calibration_control
    import acs_pkg::*;
#(
    parameter logic [31:0] CAL_DLY_SHORT_CYC = 32'h0001_0000,
    parameter logic [31:0] CAL_DLY_LONG_CYC  = 32'h0100_0000,
    parameter logic [31:0] CAL_CORE_CYC      = 32'h0000_2000,
    parameter logic [31:0] CAL_TERM_CYC      = 32'h0000_1000
) (
    // sample clock domain
    input  wire logic         ref_clk_in,
    input  wire logic         reset_in,
    input  wire logic         ce_in,
    // control pins
    input  wire logic         cal_request_pin_in,
    input  wire logic         calibration_delay_select_in,
    input  wire logic [1:0]   power_down_pin_in,
    input  wire logic         output_edge_select_in,
    // configuration from the serial control side, same clock
    input  wire acs_cfg_t     cfg_in,
    // calibration status
    output logic              calibration_active_flag_out,
    output logic              analog_power_down_out,
    output logic              termination_trim_out,
    // conversion word domain
    input  wire logic         conv_clk_in,
    input  wire acs_sample_t  sample_in,
    output acs_out_bus_t      data_bus_out,
    output logic [1:0]        data_oe_out,
    output logic              output_data_clock_out
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic       cal_pin;
    logic       dly_pin;
    logic [1:0] pd_pin;
    logic       edge_pin;
    logic       pd_any;

    acs_sync #(.W(5), .AGREE(1'b1)) u_pin_sync (
        .clk_in (ref_clk_in),
        .d_in   ({cal_request_pin_in, calibration_delay_select_in, power_down_pin_in, output_edge_select_in}),
        .q_out  ({cal_pin, dly_pin, pd_pin, edge_pin})
    );

    assign pd_any = |pd_pin;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // request qualifier: long low, then long high, filters noise on the request pin
    acs_state_t state_reg;
    acs_state_t state_next;
    logic [6:0] low_cnt_reg;
    logic [6:0] high_cnt_reg;
    logic       low_ok_reg;
    logic       req_fire;

    assign req_fire = (state_reg == ACS_ST_IDLE) && cal_pin && low_ok_reg
                      && (high_cnt_reg == ACS_REQ_HIGH_CYC - 7'h01);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            low_cnt_reg  <= 7'h00;
            high_cnt_reg <= 7'h00;
            low_ok_reg   <= 1'b0;
        end else if (ce_in) begin
            if (state_reg == ACS_ST_PDOWN || state_reg == ACS_ST_CAL) begin
                low_cnt_reg  <= 7'h00;
                high_cnt_reg <= 7'h00;
                low_ok_reg   <= 1'b0;
            end else if (!cal_pin) begin
                high_cnt_reg <= 7'h00;
                if (low_cnt_reg != ACS_REQ_LOW_CYC) begin
                    low_cnt_reg <= low_cnt_reg + 7'h01;
                end
                low_ok_reg <= (low_cnt_reg >= ACS_REQ_LOW_CYC - 7'h01);
            end else begin
                low_cnt_reg <= 7'h00;
                if (req_fire) begin
                    high_cnt_reg <= 7'h00;
                    low_ok_reg   <= 1'b0;
                end else if (low_ok_reg) begin
                    high_cnt_reg <= high_cnt_reg + 7'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // sequencer
    logic [1:0]  fill_reg;
    logic [31:0] cnt_reg;
    logic [31:0] dly_target;
    logic [31:0] cal_target;
    logic        trim_reg;
    logic        trim_now;
    logic        trim_sel;

    assign dly_target = (cfg_in.extended_mode || !dly_pin) ? CAL_DLY_SHORT_CYC : CAL_DLY_LONG_CYC;
    assign cal_target = trim_reg ? (CAL_CORE_CYC + CAL_TERM_CYC) : CAL_CORE_CYC;
    // on-command calibration trims termination unless skipped in extended mode
    assign trim_now   = !(cfg_in.extended_mode && cfg_in.trim_skip);
    // trim choice of the calibration being entered, so the indicator is right from its first cycle
    assign trim_sel   = (state_reg == ACS_ST_CAL) ? trim_reg : ((state_reg == ACS_ST_DELAY) || trim_now);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACS_ST_STRAP: begin
                if (fill_reg == ACS_STRAP_FILL) begin
                    state_next = cal_pin ? ACS_ST_IDLE : ACS_ST_DELAY;
                end
            end
            ACS_ST_DELAY: begin
                if (!pd_any && cnt_reg >= dly_target - 32'h1) begin
                    state_next = ACS_ST_CAL;
                end
            end
            ACS_ST_IDLE: begin
                if (pd_any) begin
                    state_next = ACS_ST_PDOWN;
                end else if (req_fire) begin
                    state_next = ACS_ST_CAL;
                end
            end
            ACS_ST_CAL: begin
                if (cnt_reg >= cal_target - 32'h1) begin
                    state_next = pd_any ? ACS_ST_PDOWN : ACS_ST_IDLE;
                end
            end
            ACS_ST_PDOWN: begin
                if (!pd_any) begin
                    state_next = ACS_ST_IDLE;
                end
            end
            default: begin
                state_next = ACS_ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= ACS_ST_STRAP;
        end else if (ce_in) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            fill_reg <= 2'h0;
        end else if (ce_in && fill_reg != ACS_STRAP_FILL) begin
            fill_reg <= fill_reg + 2'h1;
        end
    end

    // one counter serves the power-up delay and the calibration length
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_reg <= ACS_CNT_RST;
        end else if (ce_in) begin
            if (state_next != state_reg) begin
                cnt_reg <= ACS_CNT_RST;
            end else if (state_reg == ACS_ST_CAL || (state_reg == ACS_ST_DELAY && !pd_any)) begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            trim_reg <= 1'b0;
        end else if (ce_in) begin
            if (state_reg == ACS_ST_DELAY && state_next == ACS_ST_CAL) begin
                trim_reg <= 1'b1;
            end else if (state_reg == ACS_ST_IDLE && state_next == ACS_ST_CAL) begin
                trim_reg <= trim_now;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // status outputs
    logic [1:0] chan_pd_reg;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            calibration_active_flag_out <= 1'b0;
            termination_trim_out        <= 1'b0;
            chan_pd_reg                 <= 2'h0;
        end else if (ce_in) begin
            calibration_active_flag_out <= (state_next == ACS_ST_CAL);
            termination_trim_out        <= (state_next == ACS_ST_CAL) && trim_sel;
            // a channel only powers down once any running calibration is over
            chan_pd_reg <= (state_next == ACS_ST_CAL) ? 2'h0 : pd_pin;
        end
    end

    // held high from reset until the clock is seen running, and again in the power-down state, which either channel's power-down pin selects
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            analog_power_down_out <= ACS_ANALOG_PD_RST;
        end else if (ce_in) begin
            analog_power_down_out <= (state_next == ACS_ST_PDOWN);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // crossing into the conversion word domain; all are slow levels
    logic       x_reset;
    logic       x_ce;
    logic       x_stop;
    logic [1:0] x_pd;
    logic       x_edge;
    logic       x_ddr;

    acs_sync #(.W(7), .AGREE(1'b0)) u_link_sync (
        .clk_in (conv_clk_in),
        .d_in   ({reset_in, ce_in, calibration_active_flag_out && termination_trim_out,
                  chan_pd_reg, edge_pin, cfg_in.ddr_mode}),
        .q_out  ({x_reset, x_ce, x_stop, x_pd, x_edge, x_ddr})
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // demultiplexer and data clock
    logic         phase_reg;
    logic [7:0]   hold_a_reg;
    logic [7:0]   hold_b_reg;
    logic         output_data_clock_next;
    logic         load;

    // sdr: clock toggles every word, period two words; ddr: toggles every second word
    always_comb begin
        output_data_clock_next = output_data_clock_out;
        load      = 1'b0;
        if (!x_stop) begin
            if (!x_ddr) begin
                // level tied to the word phase, so the load edge is the selected one even after a stop
                output_data_clock_next = phase_reg ? x_edge : !x_edge;
                load      = phase_reg;
            end else if (phase_reg) begin
                output_data_clock_next = !output_data_clock_out;
                load      = 1'b1;
            end
        end
    end

    always_ff @(posedge conv_clk_in) begin
        if (x_reset) begin
            phase_reg             <= 1'b0;
            output_data_clock_out <= 1'b0;
        end else if (x_ce) begin
            phase_reg             <= !phase_reg;
            output_data_clock_out <= output_data_clock_next;
        end
    end

    // falling-edge conversions wait here for their rising-edge partners
    always_ff @(posedge conv_clk_in) begin
        if (x_reset) begin
            hold_a_reg <= ACS_CODE_RST;
            hold_b_reg <= ACS_CODE_RST;
        end else if (x_ce && !phase_reg) begin
            hold_a_reg <= {~sample_in.conv_a[7], sample_in.conv_a[6:0]};
            hold_b_reg <= {~sample_in.conv_b[7], sample_in.conv_b[6:0]};
        end
    end

    always_ff @(posedge conv_clk_in) begin
        if (x_reset) begin
            data_bus_out <= {4{ACS_CODE_RST}};
        end else if (x_ce && load) begin
            data_bus_out.a_fall <= hold_a_reg;
            data_bus_out.b_fall <= hold_b_reg;
            data_bus_out.a_rise <= {~sample_in.conv_a[7], sample_in.conv_a[6:0]};
            data_bus_out.b_rise <= {~sample_in.conv_b[7], sample_in.conv_b[6:0]};
        end
    end

    always_ff @(posedge conv_clk_in) begin
        if (x_reset) begin
            data_oe_out <= ACS_OE_RST;
        end else if (x_ce) begin
            data_oe_out <= ~x_pd;
        end
    end

endmodule

// ### acs_calibration_control_sva.sv
// acs_calibration_control_sva: port timing checks of calibration and output control.
// assumes a bind into acs_calibration_control; pins are raw, so bounds allow for synchroniser lag.
`timescale 1ns/100ps
module acs_calibration_control_sva
    import acs_pkg::*;
#(
    parameter logic [31:0] CAL_CORE_CYC = 32'h0000_2000,
    parameter logic [31:0] CAL_TERM_CYC = 32'h0000_1000
) (
    input wire logic       ref_clk_in,
    input wire logic       reset_in,
    input wire logic       conv_clk_in,
    input wire logic       cal_request_pin_in,
    input wire logic [1:0] power_down_pin_in,
    input wire logic       calibration_active_flag_out,
    input wire logic       analog_power_down_out,
    input wire logic       termination_trim_out,
    input wire logic [1:0] data_oe_out,
    input wire logic       output_data_clock_out
);
    logic [31:0] len_reg;
    logic        trim_seen_reg;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////////////////
    // length of the running calibration, cleared while idle
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !calibration_active_flag_out) begin
            len_reg       <= 32'h0000_0000;
            trim_seen_reg <= 1'b0;
        end else begin
            len_reg       <= len_reg + 32'h0000_0001;
            trim_seen_reg <= trim_seen_reg | termination_trim_out;
        end
    end
    sequence s_req_seen;
        $past(cal_request_pin_in, 80) && !$past(cal_request_pin_in, 90);
    endsequence
    sequence s_pd_held(logic [1:0] lvl);
        (power_down_pin_in == lvl && !calibration_active_flag_out) [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    trim_in_cal_a: assert property (termination_trim_out |-> calibration_active_flag_out)
        else $error("termination trim outside calibration");
    cal_len_a: assert property ($fell(calibration_active_flag_out) |-> (trim_seen_reg ?
        len_reg >= CAL_CORE_CYC + CAL_TERM_CYC : len_reg < CAL_CORE_CYC + CAL_TERM_CYC && len_reg >= CAL_CORE_CYC))
        else $error("calibration length wrong");
    cal_bound_a: assert property (calibration_active_flag_out |-> len_reg <= CAL_CORE_CYC + CAL_TERM_CYC + 32'h4)
        else $error("calibration overran");
    req_lag_a: assert property ($rose(calibration_active_flag_out) && cal_request_pin_in |-> s_req_seen)
        else $error("calibration start lag wrong");
    pd_no_cal_a: assert property (analog_power_down_out |=> !$rose(calibration_active_flag_out))
        else $error("calibration started while powered down");
    cal_power_a: assert property (calibration_active_flag_out |-> !analog_power_down_out)
        else $error("power down during calibration");
    oe_off_a: assert property (s_pd_held(2'h3) |=> ##2 data_oe_out == 2'h0)
        else $error("outputs driven in power down");
    oe_on_a: assert property (s_pd_held(2'h0) |=> ##2 data_oe_out == 2'h3)
        else $error("outputs not driven");
    output_data_clock_frozen_a: assert property (@(posedge conv_clk_in) disable iff (reset_in)
        termination_trim_out [*5] |-> $stable(output_data_clock_out))
        else $error("data clock runs during trim");
    output_data_clock_runs_a: assert property ((calibration_active_flag_out && !termination_trim_out) [*4]
        |-> ##[0:3] $changed(output_data_clock_out))
        else $error("data clock stopped without trim");
endmodule
bind acs_calibration_control acs_calibration_control_sva #(
    .CAL_CORE_CYC(CAL_CORE_CYC), .CAL_TERM_CYC(CAL_TERM_CYC)
) i_sva (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .conv_clk_in(conv_clk_in),
    .cal_request_pin_in(cal_request_pin_in), .power_down_pin_in(power_down_pin_in),
    .calibration_active_flag_out(calibration_active_flag_out), .analog_power_down_out(analog_power_down_out),
    .termination_trim_out(termination_trim_out), .data_oe_out(data_oe_out),
    .output_data_clock_out(output_data_clock_out)
);

// ### acs_calibration_control_tb.sv
// acs_calibration_control_tb: scenario tasks for calibration sequencing and output words.
// assumes shortened delay and calibration counts; pins change on the falling sample clock edge.
`timescale 1ns/100ps
module acs_calibration_control_tb
    import acs_pkg::*;
;
    logic         ref_clk_in = 1'b0;
    logic         conv_clk_in = 1'b0;
    logic         reset_in = 1'b1;
    logic         cal_pin = 1'b0;
    logic         dly_sel = 1'b0;
    logic         edge_sel = 1'b0;
    logic [1:0]   pd = 2'h0;
    logic [7:0]   k = 8'h00;
    acs_cfg_t     cfg = '0;
    acs_sample_t  sample = '0;
    acs_out_bus_t bus;
    logic         flag, apd, trim, output_data_clock;
    logic [1:0]   oe;
    int           good, bad, toggles = 0, changes = 0, errors = 0, comparisons = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    always #24 conv_clk_in = ~conv_clk_in;
    always @(negedge conv_clk_in) begin
        k <= k + 8'h01;
        sample <= '{conv_a: k, conv_b: 8'h00};
    end
    always @(output_data_clock) toggles++;
    // one new word pair per two conversions, whatever the clocking mode
    always @(bus.a_rise) changes++;
    acs_calibration_control #(
        .CAL_DLY_SHORT_CYC(32'h10), .CAL_DLY_LONG_CYC(32'h20), .CAL_CORE_CYC(32'h14), .CAL_TERM_CYC(32'h0A)
    ) i_dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(1'b1), .cal_request_pin_in(cal_pin),
        .calibration_delay_select_in(dly_sel), .power_down_pin_in(pd), .output_edge_select_in(edge_sel),
        .cfg_in(cfg), .calibration_active_flag_out(flag), .analog_power_down_out(apd),
        .termination_trim_out(trim), .conv_clk_in(conv_clk_in), .sample_in(sample), .data_bus_out(bus),
        .data_oe_out(oe), .output_data_clock_out(output_data_clock)
    );
    acs_capture_model i_rx (
        .output_data_clock_in(output_data_clock), .bus_in(bus), .oe_in(oe), .flag_in(flag), .edge_in(edge_sel),
        .ddr_in(cfg.ddr_mode), .good_out(good), .bad_out(bad)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic wait_flag(input logic lvl, input int max, output int n);
        n = 0;
        while (flag !== lvl && n < max) begin
            cyc(1);
            n++;
        end
    endtask
    // pins settle one cycle before reset so the strap sees them
    task automatic start(input acs_cfg_t c, input logic sel, input logic cal, input logic [1:0] p);
        cfg = c;
        dly_sel = sel;
        cal_pin = cal;
        pd = p;
        cyc(1);
        reset_in = 1'b1;
        cyc(2);
        check(apd, 1'b1);
        reset_in = 1'b0;
    endtask
    task automatic request(output int n);
        cal_pin = 1'b0;
        cyc(90);
        cal_pin = 1'b1;
        wait_flag(1'b1, 120, n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        int n;
        for (int i = 0; i < 4; i++) begin
            start('{extended_mode: i == 2, trim_skip: i == 2, ddr_mode: 1'b0}, i == 0 || i == 2, 1'b0,
                  (i == 3) ? 2'h3 : 2'h0);
            if (i == 3) begin
                cyc(50);
                check(flag, 1'b0);
                pd = 2'h0;
            end
            wait_flag(1'b1, 100, n);
            check(n >= ((i == 0) ? 32 : 16) && n <= ((i == 0) ? 40 : 24), 1'b1);
            check(trim, 1'b1);
            wait_flag(1'b0, 100, n);
        end
    endtask
    task automatic t_command();
        int n;
        start('0, 1'b0, 1'b1, 2'h0);
        cyc(60);
        check(flag, 1'b0);
        request(n);
        check(n >= 80 && n <= 88, 1'b1);
        check(trim, 1'b1);
        wait_flag(1'b0, 100, n);
        cfg = '{extended_mode: 1'b1, trim_skip: 1'b1, ddr_mode: 1'b0};
        request(n);
        check(trim, 1'b0);
        wait_flag(1'b0, 100, n);
        check(n <= 22, 1'b1);
        cal_pin = 1'b0;
        cyc(90);
        cal_pin = 1'b1;
        cyc(40);
        cal_pin = 1'b0;
        cyc(100);
        check(flag, 1'b0);
    endtask
    task automatic t_pdown();
        int n;
        request(n);
        pd = 2'h3;
        cyc(5);
        check(apd, 1'b0);
        wait_flag(1'b0, 100, n);
        cyc(12);
        check(apd, 1'b1);
        check(oe, 2'h0);
        request(n);
        check(n, 120);
        pd = 2'h0;
        cyc(12);
        check(oe, 2'h3);
    endtask
    task automatic t_data();
        int g, b, t, w;
        for (int i = 0; i < 3; i++) begin
            edge_sel = i[0];
            cfg.ddr_mode = (i == 2);
            cyc(20);
            g = good;
            b = bad;
            t = toggles;
            w = changes;
            repeat (40) @(posedge conv_clk_in);
            t = toggles - t;
            check(changes - w >= 19 && changes - w <= 21, 1'b1);
            check(t >= ((i == 2) ? 19 : 39) && t <= ((i == 2) ? 21 : 41), 1'b1);
            check(bad, b);
            check(good > g + 10 || i == 2, 1'b1);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // the whole sequence needs about 2000 sample clock cycles
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end
    initial begin
        t_powerup();
        t_command();
        t_pdown();
        t_data();
        wrap_up();
    end
endmodule

// ### acs_capture_model.sv
// acs_capture_model: receiver capturing the buses on the data clock edge opposite the change edge.
// assumes single data rate for checks; converter a counts up, converter b is held at zero.
`timescale 1ns/100ps
module acs_capture_model
    import acs_pkg::*;
(
    // from the converter
    input  wire logic         output_data_clock_in,
    input  wire acs_out_bus_t bus_in,
    input  wire logic [1:0]   oe_in,
    input  wire logic         flag_in,
    // receiver setup
    input  wire logic         edge_in,
    input  wire logic         ddr_in,
    // statistics
    output int                good_out,
    output int                bad_out
);
    int discard = 8;
    initial good_out = 0;
    initial bad_out = 0;
    always @(output_data_clock_in) begin
        if (oe_in !== 2'h3 || flag_in !== 1'b0) begin
            discard = 8;
        end else if (ddr_in === 1'b0 && output_data_clock_in !== edge_in) begin
            if (discard > 0) begin
                discard--;
            end else if ((bus_in.a_rise ^ 8'h80) === (bus_in.a_fall ^ 8'h80) + 8'h01
                         && bus_in.b_fall === 8'h80 && bus_in.b_rise === 8'h80) begin
                good_out++;
            end else begin
                bad_out++;
            end
        end
    end
    // words must move with the selected data clock edge
    always @(bus_in) begin
        #1;
        if (oe_in === 2'h3 && flag_in === 1'b0 && ddr_in === 1'b0) begin
            if (output_data_clock_in === edge_in) good_out++;
            else bad_out++;
        end
    end
endmodule

// ### acs_pkg.sv
// acs_pkg: shared constants and carriers of the converter calibration and output control block.
// assumes a sample clock domain for control and a conversion word clock for the output side.
package acs_pkg;

    // request qualification: least low time, least high time, start lag (sample clock cycles)
    localparam logic [6:0] ACS_REQ_LOW_CYC   = 7'h50;
    localparam logic [6:0] ACS_REQ_HIGH_CYC  = 7'h50;
    // cycles the pin synchronisers need before the power-up strap is trustworthy
    localparam logic [1:0] ACS_STRAP_FILL    = 2'h3;
    // reset values
    localparam logic       ACS_ANALOG_PD_RST = 1'b1;
    localparam logic [7:0] ACS_CODE_RST      = 8'h80;
    localparam logic [1:0] ACS_OE_RST        = 2'h0;
    localparam logic [31:0] ACS_CNT_RST      = 32'h0000_0000;

    typedef enum logic [5:0] {
        ACS_ST_STRAP  = 6'b000001,
        ACS_ST_DELAY  = 6'b000010,
        ACS_ST_IDLE   = 6'b000100,
        ACS_ST_CAL    = 6'b001000,
        ACS_ST_PDOWN  = 6'b010000,
        ACS_ST_SPARE  = 6'b100000
    } acs_state_t;

    // one conversion result per converter, two's complement from the core
    typedef struct packed {
        logic [7:0] conv_a;
        logic [7:0] conv_b;
    } acs_sample_t;

    // four demultiplexed output buses, offset binary
    typedef struct packed {
        logic [7:0] a_fall;
        logic [7:0] a_rise;
        logic [7:0] b_fall;
        logic [7:0] b_rise;
    } acs_out_bus_t;

    // static configuration from the serial control side
    typedef struct packed {
        logic extended_mode;
        logic trim_skip;
        logic ddr_mode;
    } acs_cfg_t;

endpackage
